// *** data_memory_regs.svh ***
// Constants for the data memory decoder and indirect addressing unit.
// Assumes a core that presents one access per clock with an 11-bit address.
// What this block does
// (RULE1) Reads of unimplemented special purpose locations return 00H.
// (RULE2) Ordinary special registers are read/write; protected ones ignore writes.
// (RULE3) Indirect port accesses are redirected to the location its pointer names.
// (RULE4) Port zero with pointer zero reaches sector 0 only.
// (RULE5) Ports one and two reach any sector through sector/offset pointers.
// (RULE6) An access resolving to a port reads 00H and writes nothing.
// (RULE7) Ports and pointers sit at 00H,01H,02H,03H,04H,0CH,0DH,0EH.
// (RULE8) Sector pointer picks the sector, offset pointer the location within.
// (RULE9) Offsets 00H-7FH are special registers, 80H-FFH general RAM.
// (RULE10) Writes to unimplemented special locations are dropped without error.
`ifndef DATA_MEMORY_REGS_SVH
`define DATA_MEMORY_REGS_SVH
`define OFS_PORT_ZERO 8'h00
`define OFS_POINTER_ZERO 8'h01
`define OFS_PORT_ONE 8'h02
`define OFS_POINTER_ONE_OFFSET 8'h03
`define OFS_POINTER_ONE_SECTOR 8'h04
`define OFS_PORT_TWO 8'h0C
`define OFS_POINTER_TWO_OFFSET 8'h0D
`define OFS_POINTER_TWO_SECTOR 8'h0E
`define POINTER_RESET 8'h00
`define READ_ZERO 8'h00
`define GP_BIT 7
`define SECTOR_BITS 3
`define RAM_ADDR_BITS 10
`endif

// *** data_memory_pkg.sv ***
// Types shared by the data memory decoder and its RAM.
// Assumes the constants header is included by users that need offsets.
package data_memory_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] sector_t;
  typedef logic [9:0] ram_addr_t;
  typedef enum logic [3:0] {
    TGT_NONE = 4'h1,
    TGT_POINTER = 4'h2,
    TGT_SPECIAL = 4'h4,
    TGT_RAM = 4'h8
  } target_e;
endpackage

// *** gp_ram.sv ***
// General purpose data RAM, eight sectors of 128 bytes.
// Assumes one access per clock; read data is registered.
`timescale 1ns/100ps
module gp_ram (
  input wire logic mclk,
  input wire logic rst,
  input wire logic we,
  input wire logic re,
  input wire data_memory_pkg::ram_addr_t addr,
  input wire data_memory_pkg::byte_t wdata,
  output data_memory_pkg::byte_t rdata
);
  data_memory_pkg::byte_t mem [0:1023];
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (re) begin
      rdata <= mem[addr];
    end
  end
endmodule

// *** data_memory_decoder.sv ***
// Data memory address decoder with three indirect ports and five pointers.
// Assumes the core issues at most one read or write per cycle; read data one cycle later.
// External special registers answer on sfr_rdata combinationally for the address on sfr_addr.
`include "data_memory_regs.svh"
`timescale 1ns/100ps
module data_memory_decoder (
  input wire logic mclk,
  input wire logic rst,
  input wire logic core_re,
  input wire logic core_we,
  input wire logic [10:0] core_addr,
  input wire data_memory_pkg::byte_t core_wdata,
  output data_memory_pkg::byte_t core_rdata,
  output logic [10:0] sfr_addr,
  output logic sfr_we,
  output logic sfr_re,
  output data_memory_pkg::byte_t sfr_wdata,
  input wire data_memory_pkg::byte_t sfr_rdata,
  input wire logic sfr_present,
  input wire logic sfr_protected,
  output data_memory_pkg::byte_t pointer_zero,
  output data_memory_pkg::byte_t pointer_one_offset,
  output data_memory_pkg::byte_t pointer_one_sector,
  output data_memory_pkg::byte_t pointer_two_offset,
  output data_memory_pkg::byte_t pointer_two_sector
);
  data_memory_pkg::byte_t p0_q, p0_d, p1o_q, p1o_d, p1s_q, p1s_d, p2o_q, p2o_d, p2s_q, p2s_d;
  data_memory_pkg::byte_t hold_q, hold_d;
  logic ram_sel_q, ram_sel_d;
  logic [10:0] eff;
  data_memory_pkg::target_e tgt;
  logic ram_we, ram_re;
  data_memory_pkg::byte_t ram_rdata;

  // Port locations exist only in sector 0; other sectors hold no port there
  function automatic logic is_port(input logic [10:0] a);
    is_port = (a[10:8] == 3'h0) && (a[7:0] == `OFS_PORT_ZERO || a[7:0] == `OFS_PORT_ONE ||
      a[7:0] == `OFS_PORT_TWO);
  endfunction

  function automatic logic is_pointer(input logic [10:0] a);
    is_pointer = (a[10:8] == 3'h0) && (a[7:0] == `OFS_POINTER_ZERO ||
      a[7:0] == `OFS_POINTER_ONE_OFFSET || a[7:0] == `OFS_POINTER_ONE_SECTOR ||
      a[7:0] == `OFS_POINTER_TWO_OFFSET || a[7:0] == `OFS_POINTER_TWO_SECTOR);
  endfunction

  // Redirection through the paired pointer
  always_comb begin
    eff = core_addr;
    if (core_addr[10:8] == 3'h0 && core_addr[7:0] == `OFS_PORT_ZERO) begin
      eff = {3'h0, p0_q}; // [RULE3] [RULE4]
    end else if (core_addr[10:8] == 3'h0 && core_addr[7:0] == `OFS_PORT_ONE) begin
      eff = {p1s_q[2:0], p1o_q}; // [RULE3] [RULE5] [RULE8]
    end else if (core_addr[10:8] == 3'h0 && core_addr[7:0] == `OFS_PORT_TWO) begin
      eff = {p2s_q[2:0], p2o_q}; // [RULE3] [RULE5] [RULE8]
    end
  end

  // Port test comes first so a pointer aimed at a port reads 00H and writes nothing
  always_comb begin
    if (is_port(eff)) begin
      tgt = data_memory_pkg::TGT_NONE; // [RULE6]
    end else if (eff[`GP_BIT]) begin
      tgt = data_memory_pkg::TGT_RAM; // [RULE9]
    end else if (is_pointer(eff)) begin
      tgt = data_memory_pkg::TGT_POINTER; // [RULE7]
    end else if (sfr_present) begin
      tgt = data_memory_pkg::TGT_SPECIAL;
    end else begin
      tgt = data_memory_pkg::TGT_NONE; // [RULE1] [RULE10]
    end
  end

  // Strobes reach only the storage that the effective address selects
  assign sfr_addr = eff;
  assign sfr_wdata = core_wdata;
  assign sfr_re = core_re && (tgt == data_memory_pkg::TGT_SPECIAL);
  assign sfr_we = core_we && (tgt == data_memory_pkg::TGT_SPECIAL) && !sfr_protected; // [RULE2]
  assign ram_we = core_we && (tgt == data_memory_pkg::TGT_RAM);
  assign ram_re = core_re && (tgt == data_memory_pkg::TGT_RAM);

  gp_ram u_ram (
    .mclk(mclk),
    .rst(rst),
    .we(ram_we),
    .re(ram_re),
    .addr({eff[10:8], eff[6:0]}),
    .wdata(core_wdata),
    .rdata(ram_rdata)
  );

  // Pointer registers and registered read path
  always_comb begin
    p0_d = p0_q;
    p1o_d = p1o_q;
    p1s_d = p1s_q;
    p2o_d = p2o_q;
    p2s_d = p2s_q;
    hold_d = hold_q;
    ram_sel_d = ram_sel_q;
    if (core_we && tgt == data_memory_pkg::TGT_POINTER) begin
      unique case (eff[7:0])
        `OFS_POINTER_ZERO: p0_d = core_wdata;
        `OFS_POINTER_ONE_OFFSET: p1o_d = core_wdata;
        `OFS_POINTER_ONE_SECTOR: p1s_d = core_wdata;
        `OFS_POINTER_TWO_OFFSET: p2o_d = core_wdata;
        `OFS_POINTER_TWO_SECTOR: p2s_d = core_wdata;
        default: p0_d = p0_q;
      endcase
    end
    if (core_re) begin
      ram_sel_d = (tgt == data_memory_pkg::TGT_RAM);
      unique case (tgt)
        data_memory_pkg::TGT_POINTER: begin
          unique case (eff[7:0])
            `OFS_POINTER_ZERO: hold_d = p0_q;
            `OFS_POINTER_ONE_OFFSET: hold_d = p1o_q;
            `OFS_POINTER_ONE_SECTOR: hold_d = p1s_q;
            `OFS_POINTER_TWO_OFFSET: hold_d = p2o_q;
            `OFS_POINTER_TWO_SECTOR: hold_d = p2s_q;
            default: hold_d = `READ_ZERO;
          endcase
        end
        data_memory_pkg::TGT_SPECIAL: hold_d = sfr_rdata;
        data_memory_pkg::TGT_RAM: hold_d = `READ_ZERO;
        data_memory_pkg::TGT_NONE: hold_d = `READ_ZERO; // [RULE1] [RULE6]
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      p0_q <= `POINTER_RESET;
      p1o_q <= `POINTER_RESET;
      p1s_q <= `POINTER_RESET;
      p2o_q <= `POINTER_RESET;
      p2s_q <= `POINTER_RESET;
      hold_q <= `READ_ZERO;
      ram_sel_q <= 1'b0;
    end else begin
      p0_q <= p0_d;
      p1o_q <= p1o_d;
      p1s_q <= p1s_d;
      p2o_q <= p2o_d;
      p2s_q <= p2s_d;
      hold_q <= hold_d;
      ram_sel_q <= ram_sel_d;
    end
  end

  // Read data held until the next read; RAM data comes from its output register
  assign core_rdata = ram_sel_q ? ram_rdata : hold_q;
  assign pointer_zero = p0_q;
  assign pointer_one_offset = p1o_q;
  assign pointer_one_sector = p1s_q;
  assign pointer_two_offset = p2o_q;
  assign pointer_two_sector = p2s_q;

  logic none_rd;
  assign none_rd = core_re && tgt == data_memory_pkg::TGT_NONE;

  property p_unmapped_zero;
    @(posedge mclk) disable iff (rst) none_rd |=> core_rdata == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero"); // [RULE1]

  property p_protected;
    @(posedge mclk) disable iff (rst) sfr_protected |-> !sfr_we;
  endproperty
  a_protected: assert property (p_protected) else $error("write reached protected register"); // [RULE2]

  property p_port_no_pointer_write;
    @(posedge mclk) disable iff (rst) (core_we && is_port(core_addr) && is_port(eff)) |=> $stable(p0_q);
  endproperty
  a_port_no_pointer_write: assert property (p_port_no_pointer_write) else $error("port write hit pointer"); // [RULE6]

  property p_port_zero_sector;
    @(posedge mclk) disable iff (rst) (core_addr == 11'h000) |-> eff[10:8] == 3'h0;
  endproperty
  a_port_zero_sector: assert property (p_port_zero_sector) else $error("port zero left sector 0"); // [RULE4]

  property p_port_one_redirect;
    @(posedge mclk) disable iff (rst) (core_addr == 11'h002) |-> eff == {p1s_q[2:0], p1o_q};
  endproperty
  a_port_one_redirect: assert property (p_port_one_redirect) else $error("port one misdirected"); // [RULE5]

  property p_port_two_redirect;
    @(posedge mclk) disable iff (rst) (core_addr == 11'h00C) |-> eff == {p2s_q[2:0], p2o_q};
  endproperty
  a_port_two_redirect: assert property (p_port_two_redirect) else $error("port two misdirected"); // [RULE8]

  property p_pointer_write;
    @(posedge mclk) disable iff (rst) (core_we && core_addr == 11'h001) |=> p0_q == $past(core_wdata);
  endproperty
  a_pointer_write: assert property (p_pointer_write) else $error("pointer zero not written"); // [RULE7]

  property p_gp_to_ram;
    @(posedge mclk) disable iff (rst) (core_we && eff[7] && !is_port(eff)) |-> ram_we && !sfr_we;
  endproperty
  a_gp_to_ram: assert property (p_gp_to_ram) else $error("general area write not to RAM"); // [RULE9]

  property p_redirect_sfr;
    @(posedge mclk) disable iff (rst) (core_we && is_port(core_addr)) |-> !(sfr_we && sfr_addr == core_addr);
  endproperty
  a_redirect_sfr: assert property (p_redirect_sfr) else $error("port address itself written"); // [RULE3]

  property p_unmapped_drop;
    @(posedge mclk) disable iff (rst) (core_we && none_rd == 1'b0 && tgt == data_memory_pkg::TGT_NONE)
      |-> !sfr_we && !ram_we;
  endproperty
  a_unmapped_drop: assert property (p_unmapped_drop) else $error("unmapped write not dropped"); // [RULE10]

  // Read-back of the pointers through the hold register
  property p_rb_zero;
    @(posedge mclk) disable iff (rst) (core_re && core_addr == {3'h0, `OFS_POINTER_ZERO})
      |=> core_rdata == $past(p0_q);
  endproperty
  a_rb_zero: assert property (p_rb_zero) else $error("pointer read-back wrong"); // [RULE7]

  property p_rb_one_offset;
    @(posedge mclk) disable iff (rst) (core_re && core_addr == {3'h0, `OFS_POINTER_ONE_OFFSET})
      |=> core_rdata == $past(p1o_q);
  endproperty
  a_rb_one_offset: assert property (p_rb_one_offset) else $error("pointer read-back wrong"); // [RULE7]

  property p_rb_one_sector;
    @(posedge mclk) disable iff (rst) (core_re && core_addr == {3'h0, `OFS_POINTER_ONE_SECTOR})
      |=> core_rdata == $past(p1s_q);
  endproperty
  a_rb_one_sector: assert property (p_rb_one_sector) else $error("pointer read-back wrong"); // [RULE7]

  property p_rb_two_offset;
    @(posedge mclk) disable iff (rst) (core_re && core_addr == {3'h0, `OFS_POINTER_TWO_OFFSET})
      |=> core_rdata == $past(p2o_q);
  endproperty
  a_rb_two_offset: assert property (p_rb_two_offset) else $error("pointer read-back wrong"); // [RULE7]

  property p_rb_two_sector;
    @(posedge mclk) disable iff (rst) (core_re && core_addr == {3'h0, `OFS_POINTER_TWO_SECTOR})
      |=> core_rdata == $past(p2s_q);
  endproperty
  a_rb_two_sector: assert property (p_rb_two_sector) else $error("pointer read-back wrong"); // [RULE7]

  // Decode and strobe checks
  property p_rdata_stands;
    @(posedge mclk) disable iff (rst) !core_re |=> $stable(core_rdata);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved without read"); // [RULE9]

  property p_pointers_hold;
    @(posedge mclk) disable iff (rst) !(core_we && tgt == data_memory_pkg::TGT_POINTER)
      |=> $stable(p0_q) && $stable(p1o_q) && $stable(p1s_q) && $stable(p2o_q) && $stable(p2s_q);
  endproperty
  a_pointers_hold: assert property (p_pointers_hold) else $error("pointer changed without write"); // [RULE10]

  property p_port_read_quiet;
    @(posedge mclk) disable iff (rst) (core_re && tgt == data_memory_pkg::TGT_NONE) |-> !sfr_re && !ram_re;
  endproperty
  a_port_read_quiet: assert property (p_port_read_quiet) else $error("empty read strobed storage"); // [RULE6]

  property p_sfr_window;
    @(posedge mclk) disable iff (rst) (sfr_re || sfr_we) |-> !sfr_addr[7] && sfr_present;
  endproperty
  a_sfr_window: assert property (p_sfr_window) else $error("special strobe outside special area"); // [RULE9]

  property p_ram_not_sfr;
    @(posedge mclk) disable iff (rst) (ram_re || ram_we) |-> !sfr_re && !sfr_we;
  endproperty
  a_ram_not_sfr: assert property (p_ram_not_sfr) else $error("RAM and special strobes together"); // [RULE9]

  property p_ram_general_only;
    @(posedge mclk) disable iff (rst) (ram_re || ram_we) |-> eff[7] && !is_port(eff);
  endproperty
  a_ram_general_only: assert property (p_ram_general_only) else $error("RAM strobe below 80H"); // [RULE9]

  property p_sfr_addr_no_port;
    @(posedge mclk) disable iff (rst) (sfr_re || sfr_we) |-> !is_port(sfr_addr);
  endproperty
  a_sfr_addr_no_port: assert property (p_sfr_addr_no_port) else $error("port address reached special side"); // [RULE3]

  property p_special_read;
    @(posedge mclk) disable iff (rst) (core_re && tgt == data_memory_pkg::TGT_SPECIAL) |-> sfr_re;
  endproperty
  a_special_read: assert property (p_special_read) else $error("special read not strobed"); // [RULE2]

  property p_port_zero_ram;
    @(posedge mclk) disable iff (rst) (core_we && core_addr == 11'h000 && p0_q[7])
      |-> ram_we && eff == {3'h0, p0_q};
  endproperty
  a_port_zero_ram: assert property (p_port_zero_ram) else $error("port zero RAM write misplaced"); // [RULE4]

  property p_port_one_ram;
    @(posedge mclk) disable iff (rst) (core_re && core_addr == 11'h002 && p1o_q[7])
      |-> ram_re && eff[10:8] == p1s_q[2:0];
  endproperty
  a_port_one_ram: assert property (p_port_one_ram) else $error("port one RAM read misplaced"); // [RULE5]

  property p_port_two_ram;
    @(posedge mclk) disable iff (rst) (core_re && core_addr == 11'h00C && p2o_q[7])
      |-> ram_re && eff[10:8] == p2s_q[2:0];
  endproperty
  a_port_two_ram: assert property (p_port_two_ram) else $error("port two RAM read misplaced"); // [RULE8]

  // Main scenarios
  c_port_one_read: cover property (@(posedge mclk) disable iff (rst) core_re && core_addr == 11'h002 && eff[7]);
  c_port_two_sector: cover property (@(posedge mclk) disable iff (rst)
    core_we && core_addr == 11'h00C && eff[10:8] != 3'h0);
  c_protected_write: cover property (@(posedge mclk) disable iff (rst)
    core_we && tgt == data_memory_pkg::TGT_SPECIAL && sfr_protected);
  c_pointer_via_port: cover property (@(posedge mclk) disable iff (rst)
    core_we && core_addr == 11'h002 && tgt == data_memory_pkg::TGT_POINTER);
  c_port_to_port: cover property (@(posedge mclk) disable iff (rst)
    core_re && core_addr == 11'h000 && is_port(eff));
endmodule

// *** sfr_model.sv ***
// Partner model of the external special registers behind the decoder.
// Assumes sector 0 offsets 10H-1FH are present and 1FH is flagged read-only; the decoder must withhold its writes.
`timescale 1ns/100ps
module sfr_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [10:0] sfr_addr,
  input wire logic sfr_we,
  input wire logic sfr_re,
  input wire data_memory_pkg::byte_t sfr_wdata,
  output data_memory_pkg::byte_t sfr_rdata,
  output logic sfr_present,
  output logic sfr_protected
);
  data_memory_pkg::byte_t regs_q [0:15];
  assign sfr_present = sfr_addr[10:4] == 7'h01;
  assign sfr_protected = sfr_present && sfr_addr[3:0] == 4'hF;
  // Data shows only under the read strobe; otherwise a changing pattern, never a stale value
  assign sfr_rdata = (sfr_present && sfr_re) ? regs_q[sfr_addr[3:0]] : ~sfr_addr[7:0];
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) regs_q[i] <= (i == 15) ? 8'h5A : 8'h00;
    end else if (sfr_we && sfr_present) begin
      regs_q[sfr_addr[3:0]] <= sfr_wdata;
    end
  end
endmodule

// *** sector_data_memory_indirect_access_test.sv ***
// Self-checking bench for the data memory decoder with a reference model.
// Assumes the decoder holds the general RAM and answers reads one cycle later.
`timescale 1ns/100ps
module sector_data_memory_indirect_access_test;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic core_re = 1'b0;
  logic core_we = 1'b0;
  logic [10:0] core_addr = 11'h000;
  data_memory_pkg::byte_t core_wdata = 8'h00;
  data_memory_pkg::byte_t core_rdata, sfr_rdata, sfr_wdata;
  data_memory_pkg::byte_t ptr [0:4];
  logic [10:0] sfr_addr, a;
  logic sfr_we, sfr_re, sfr_present, sfr_protected;
  logic [7:0] m_ram [0:1023];
  logic [7:0] m_sfr [0:15];
  logic [7:0] mp [0:4];
  logic [7:0] exp_q;
  logic chk_q = 1'b0;
  logic [7:0] sel [0:7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h0C, 8'h0D, 8'h0E};
  logic [31:0] r;
  integer seed = 32'h0f3c;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  always #12.5 mclk = ~mclk;
  data_memory_decoder dut (.mclk(mclk), .rst(rst), .core_re(core_re), .core_we(core_we),
    .core_addr(core_addr), .core_wdata(core_wdata), .core_rdata(core_rdata), .sfr_addr(sfr_addr),
    .sfr_we(sfr_we), .sfr_re(sfr_re), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .sfr_present(sfr_present), .sfr_protected(sfr_protected), .pointer_zero(ptr[0]),
    .pointer_one_offset(ptr[1]), .pointer_one_sector(ptr[2]), .pointer_two_offset(ptr[3]),
    .pointer_two_sector(ptr[4]));
  sfr_model far (.mclk(mclk), .rst(rst), .sfr_addr(sfr_addr), .sfr_we(sfr_we), .sfr_re(sfr_re),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_present(sfr_present),
    .sfr_protected(sfr_protected));
  function automatic int pidx(logic [10:0] e);
    if (e[10:8] != 3'h0) return 9;
    case (e[7:0])
      8'h01: return 0;
      8'h03: return 1;
      8'h04: return 2;
      8'h0D: return 3;
      8'h0E: return 4;
      default: return 9;
    endcase
  endfunction
  function automatic logic [10:0] eff(logic [10:0] e);
    if (e[10:8] != 3'h0) return e;
    case (e[7:0])
      8'h00: return {3'h0, mp[0]};
      8'h02: return {mp[2][2:0], mp[1]};
      8'h0C: return {mp[4][2:0], mp[3]};
      default: return e;
    endcase
  endfunction
  function automatic logic [7:0] rd(logic [10:0] e);
    if (e[7]) return m_ram[{e[10:8], e[6:0]}];
    if (pidx(e) < 5) return mp[pidx(e)];
    if (e[10:4] == 7'h01) return m_sfr[e[3:0]];
    return 8'h00;
  endfunction
  function automatic void wr(logic [10:0] e, logic [7:0] d);
    if (e[7]) m_ram[{e[10:8], e[6:0]}] = d;
    else if (pidx(e) < 5) mp[pidx(e)] = d;
    else if (e[10:4] == 7'h01 && e[3:0] != 4'hF) m_sfr[e[3:0]] = d;
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic op(input logic re, input logic we, input logic [10:0] addr, input logic [7:0] d);
    logic [10:0] e;
    logic [7:0] x;
    e = eff(addr);
    x = rd(e);
    core_re <= re;
    core_we <= we;
    core_addr <= addr;
    core_wdata <= d;
    @(posedge mclk);
    // Model state moves at the edge that takes the write, as the design does
    if (we) wr(e, d);
    chk_q <= re;
    exp_q <= x;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(negedge mclk) begin
    if (!rst) begin
      if (chk_q) check("core_rdata", core_rdata, exp_q);
      for (int i = 0; i < 5; i++) check("pointer", ptr[i], mp[i]);
    end
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    for (int i = 0; i < 16; i++) m_sfr[i] = (i == 15) ? 8'h5A : 8'h00;
    for (int i = 0; i < 5; i++) mp[i] = 8'h00;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 1024; i++) begin
      r = $random(seed);
      op(1'b0, 1'b1, {i[9:7], 1'b1, i[6:0]}, r[7:0]);
    end
    $display("test fill done");
    op(1'b0, 1'b1, 11'h004, 8'h05);
    op(1'b0, 1'b1, 11'h001, 8'h90);
    op(1'b1, 1'b0, 11'h000, 8'h00);
    op(1'b0, 1'b1, 11'h003, 8'hFF);
    op(1'b0, 1'b1, 11'h002, 8'h3C);
    op(1'b1, 1'b0, 11'h5FF, 8'h00);
    op(1'b0, 1'b1, 11'h001, 8'h02);
    op(1'b0, 1'b1, 11'h000, 8'h77);
    op(1'b1, 1'b0, 11'h000, 8'h00);
    op(1'b0, 1'b1, 11'h01F, 8'h11);
    op(1'b1, 1'b0, 11'h01F, 8'h00);
    op(1'b0, 1'b1, 11'h030, 8'h22);
    op(1'b1, 1'b0, 11'h030, 8'h00);
    op(1'b0, 1'b1, 11'h00E, 8'hF8);
    op(1'b0, 1'b1, 11'h00D, 8'h12);
    op(1'b0, 1'b1, 11'h00C, 8'h44);
    op(1'b1, 1'b0, 11'h012, 8'h00);
    op(1'b1, 1'b0, 11'h30C, 8'h00);
    $display("test corners done");
    repeat (600) begin
      r = $random(seed);
      a = (r[3:2] == 2'h0) ? {3'h0, sel[r[6:4]]} : r[26:16];
      op(r[0], ~r[0], a, r[15:8]);
    end
    op(1'b0, 1'b0, 11'h000, 8'h00);
    $display("test random done");
    end_of_test();
  end
endmodule
